// ---- rtl/tig_timer.sv ----
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tig_timer
  import tig_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned RESP_MAX = RESP_CYCLES,
  parameter int unsigned QUEUE_W  = 4
) (
  // clocking
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  // register port
  input  wire logic [7:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [31:0]                rdata,
  // main-program bits
  input  wire logic [tig_pkg::NUM_BITS-1:0] passed_in_bit,
  output logic      [tig_pkg::NUM_BITS-1:0] routine_in_bit,
  input  wire logic [tig_pkg::NUM_BITS-1:0] routine_out_bit,
  input  wire logic                       routine_done,
  output logic      [tig_pkg::NUM_BITS-1:0] returned_out_bit,
  // routine request and status
  output logic                            routine_req,
  output logic      [31:0]                elapsed_time_out,
  output logic                            irq
);
  import tig_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [3:0]  ctrl_reg;
  logic [31:0] delay_setpoint;
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic [1:0]  status_next;
  logic        activate;
  logic        load_delay_value;
  logic        halt_count;
  tig_mode_t   mode;

  assign activate         = ctrl_reg[CTRL_ACT_BIT];
  assign load_delay_value = ctrl_reg[CTRL_LOAD_BIT];
  assign halt_count       = ctrl_reg[CTRL_HALT_BIT];
  assign mode             = tig_mode_t'(ctrl_reg[CTRL_MODE_BIT]);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg       <= CTRL_RESET;
      delay_setpoint <= SETPOINT_RESET;
      mask_reg       <= MASK_RESET;
    end else if (ce && wr) begin
      case (addr)
        ADDR_CTRL:     ctrl_reg       <= wdata[3:0];
        ADDR_SETPOINT: delay_setpoint <= wdata;
        ADDR_MASK:     mask_reg       <= wdata[1:0];
        default:       ;
      endcase
    end
  end

  // ************************************************************
  // countdown
  // ************************************************************
  typedef enum logic [1:0] {TIG_IDLE, TIG_RUN, TIG_DONE} tig_state_t;
  tig_state_t  state_reg;
  logic [31:0] steps_total;
  logic [31:0] remain_reg;
  logic [31:0] elapsed_reg;
  logic        phase_reg;
  logic        step;
  logic        expire;
  logic        running;

  // rounding setpoint down to whole 10 ms steps, at least one step
  assign steps_total = (delay_setpoint < 32'(TICK_MS)) ? 32'h1
                     : delay_setpoint / 32'(TICK_MS);
  assign running     = (state_reg == TIG_RUN) && activate;
  assign expire      = running && step && !halt_count && (remain_reg == 32'h1)
                       && !load_delay_value;

  tig_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .clear (!running || load_delay_value),
    .hold  (halt_count),
    .step  (step)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= TIG_IDLE;
      remain_reg  <= 32'h0;
      elapsed_reg <= 32'h0;
      phase_reg   <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        TIG_IDLE: begin
          if (activate) begin
            state_reg   <= TIG_RUN;
            remain_reg  <= steps_total;
            elapsed_reg <= 32'h0;
            phase_reg   <= 1'b0;
          end
        end
        TIG_RUN: begin
          if (!activate) begin
            state_reg <= TIG_IDLE;
          end else if (load_delay_value) begin
            remain_reg  <= steps_total;
            elapsed_reg <= 32'h0;
          end else if (step && !halt_count) begin
            if (remain_reg == 32'h1) begin
              elapsed_reg <= 32'h0;
              if (mode == TIG_INTERVAL) begin
                remain_reg <= steps_total;
                phase_reg  <= ~phase_reg;
              end else begin
                remain_reg <= 32'h0;
                state_reg  <= TIG_DONE;
              end
            end else begin
              remain_reg  <= remain_reg - 32'h1;
              elapsed_reg <= elapsed_reg + 32'(TICK_MS);
            end
          end
        end
        TIG_DONE: begin
          if (!activate) begin
            state_reg <= TIG_IDLE;
          end else if (load_delay_value) begin
            state_reg  <= TIG_RUN;
            remain_reg <= steps_total;
            elapsed_reg <= 32'h0;
          end
        end
        default: state_reg <= TIG_IDLE;
      endcase
    end
  end

  // ************************************************************
  // routine requests
  // ************************************************************
  // expiries that land while a routine still runs are counted, up to 14 besides the running one; further ones are dropped and set the late status bit
  logic pending;
  logic overflow;
  logic pop;

  assign pop = routine_req && routine_done;

  tig_req_queue #(
    .CW (QUEUE_W)
  ) u_queue (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .push     (expire),
    .pop      (pop),
    .flush    (!activate),
    .pending  (pending),
    .overflow (overflow)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      routine_req <= 1'b0;
    end else if (ce) begin
      if (!activate) begin
        routine_req <= 1'b0;
      end else if (pop) begin
        routine_req <= 1'b0;
      end else if (expire || pending) begin
        routine_req <= 1'b1;
      end
    end
  end

  // bit passing; inputs frozen at request start so the routine sees one snapshot
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BITS; gi++) begin : g_bits
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          routine_in_bit[gi]   <= 1'b0;
          returned_out_bit[gi] <= 1'b0;
        end else if (ce) begin
          if (!routine_req) begin
            routine_in_bit[gi] <= passed_in_bit[gi];
          end
          if (pop) begin
            returned_out_bit[gi] <= routine_out_bit[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      elapsed_time_out <= 32'h0;
    end else if (ce) begin
      elapsed_time_out <= elapsed_reg;
    end
  end

  // ************************************************************
  // interrupt status and read port
  // ************************************************************
  always_comb begin
    status_next = status_reg;
    if (wr && addr == ADDR_STATUS) begin
      status_next = status_next & ~wdata[1:0];
    end
    if (expire) begin
      status_next[STAT_EXPIRE_BIT] = 1'b1;
    end
    if (overflow) begin
      status_next[STAT_LATE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= 2'h0;
      irq        <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (ce) begin
      rdata <= 32'h0;
      if (rd) begin
        case (addr)
          ADDR_CTRL:     rdata <= {28'h0, ctrl_reg};
          ADDR_SETPOINT: rdata <= delay_setpoint;
          ADDR_ELAPSED:  rdata <= elapsed_reg;
          ADDR_STATUS:   rdata <= {28'h0, phase_reg, running, status_reg};
          ADDR_MASK:     rdata <= {30'h0, mask_reg};
          ADDR_BITS:     rdata <= {24'h0, returned_out_bit, routine_in_bit};
          default:       rdata <= 32'h0;
        endcase
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [31:0] wait_cnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= 32'h0;
    end else if (ce) begin
      wait_cnt <= (routine_req && !routine_done) ? wait_cnt + 32'h1 : 32'h0;
    end
  end

  sequence s_expire;
    ce && expire;
  endsequence

  property p_idle_quiet;
    @(posedge clk) disable iff (reset) ce && !activate |=> !routine_req;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("request while inactive");

  property p_load;
    @(posedge clk) disable iff (reset)
      ce && load_delay_value && state_reg == TIG_RUN && activate |=> remain_reg == steps_total;
  endproperty
  a_load: assert property (p_load) else $error("load did not restore");

  property p_halt;
    @(posedge clk) disable iff (reset)
      ce && halt_count && activate && !load_delay_value && state_reg == TIG_RUN
      |=> $stable(remain_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");

  property p_start;
    @(posedge clk) disable iff (reset)
      ce && state_reg == TIG_IDLE && activate |=> remain_reg == $past(steps_total);
  endproperty
  a_start: assert property (p_start) else $error("start value wrong");

  property p_fire;
    @(posedge clk) disable iff (reset) s_expire ##0 !pop |=> routine_req;
  endproperty
  a_fire: assert property (p_fire) else $error("no request on expiry");

  // an expiry meeting a completion keeps the one-cycle request gap, then rises
  property p_fire_late;
    @(posedge clk) disable iff (reset)
      s_expire ##0 pop ##1 (ce && activate) |=> routine_req;
  endproperty
  a_fire_late: assert property (p_fire_late) else $error("queued request not raised");

  property p_once;
    @(posedge clk) disable iff (reset)
      s_expire ##0 (mode == TIG_ONDELAY) |=> state_reg == TIG_DONE;
  endproperty
  a_once: assert property (p_once) else $error("on-delayed did not stop");

  property p_reload;
    @(posedge clk) disable iff (reset)
      s_expire ##0 (mode == TIG_INTERVAL) |=> remain_reg == $past(steps_total)
                                              && phase_reg != $past(phase_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("interval did not restart");

  property p_elapsed;
    @(posedge clk) disable iff (reset) ce |=> elapsed_time_out == $past(elapsed_reg);
  endproperty
  a_elapsed: assert property (p_elapsed) else $error("elapsed out stale");

  property p_resp;
    @(posedge clk) disable iff (reset) wait_cnt <= 32'(RESP_MAX);
  endproperty
  a_resp: assert property (p_resp) else $error("routine response too slow");
endmodule

// ---- rtl/tig_pkg.sv ----
package tig_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RESP_MS         = 1;
  localparam int unsigned RESP_CYCLES     = (RESP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SETPOINT_W      = 32;
  localparam int unsigned NUM_BITS        = 4;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SETPOINT   = 8'h04;
  localparam logic [7:0]  ADDR_ELAPSED    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
  localparam logic [7:0]  ADDR_MASK       = 8'h10;
  localparam logic [7:0]  ADDR_BITS       = 8'h14;
  localparam int unsigned CTRL_ACT_BIT    = 0;
  localparam int unsigned CTRL_LOAD_BIT   = 1;
  localparam int unsigned CTRL_HALT_BIT   = 2;
  localparam int unsigned CTRL_MODE_BIT   = 3;
  localparam int unsigned STAT_EXPIRE_BIT = 0;
  localparam int unsigned STAT_LATE_BIT   = 1;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam logic [1:0]  MASK_RESET      = 2'h0;
  localparam logic [31:0] SETPOINT_RESET  = 32'h0000_0000;
  typedef enum logic {TIG_ONDELAY, TIG_INTERVAL} tig_mode_t;
endpackage

// ---- rtl/tig_tick.sv ----
`timescale 1ns/1ps
// 10 ms step generator, frozen while hold is high unless clear is set
module tig_tick #(
  parameter int unsigned DIV = 1000000
) (
  // clocking
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // control
  input  wire logic clear,
  input  wire logic hold,
  output logic      step
);
  logic [31:0] cnt_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 32'h0;
      step    <= 1'b0;
    end else if (ce) begin
      // a step that lands under hold is kept until hold lifts, so no time is lost
      if (clear || !hold) begin
        step <= 1'b0;
      end
      if (clear) begin
        cnt_reg <= 32'h0;
      end else if (!hold) begin
        if (cnt_reg == 32'(DIV - 1)) begin
          cnt_reg <= 32'h0;
          step    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  end
endmodule

// ---- rtl/tig_req_queue.sv ----
`timescale 1ns/1ps
// pending-request counter: requests are served one by one in arrival order
module tig_req_queue #(
  parameter int unsigned CW = 4
) (
  // clocking
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // requests
  input  wire logic push,
  input  wire logic pop,
  input  wire logic flush,
  output logic      pending,
  output logic      overflow
);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg  <= '0;
      overflow <= 1'b0;
    end else if (ce) begin
      overflow <= 1'b0;
      if (flush) begin
        cnt_reg <= '0;
      end else if (push && !(pop && cnt_reg != '0)) begin
        if (cnt_reg == '1) begin
          overflow <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else if (pop && !push && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign pending = (cnt_reg != '0);
endmodule

// ---- tb/tig_routine_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// routine side: answers each request lat+1 cycles after it rises
// ************************************************************
module tig_routine_model (
  // clocking
  input  wire logic                         clk,
  input  wire logic                         reset,
  // routine link
  input  wire logic                         routine_req,
  input  wire logic [tig_pkg::NUM_BITS-1:0] routine_in_bit,
  input  wire logic [3:0]                   lat,
  output logic                              routine_done,
  output logic      [tig_pkg::NUM_BITS-1:0] routine_out_bit,
  output int                                runs
);
  import tig_pkg::*;
  logic [3:0] cnt_reg;
  logic       gap_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      routine_done    <= 1'b0;
      routine_out_bit <= '0;
      runs            <= 0;
      cnt_reg         <= '0;
      gap_reg         <= 1'b0;
    end else if (routine_done) begin
      routine_done    <= 1'b0;
      // released bits must not keep looking valid
      routine_out_bit <= ~routine_out_bit;
      gap_reg         <= 1'b1;
    end else if (gap_reg) begin
      // request drops a cycle after done; never answer it twice
      gap_reg <= 1'b0;
    end else if (routine_req) begin
      if (cnt_reg >= lat) begin
        routine_done    <= 1'b1;
        routine_out_bit <= ~routine_in_bit;
        runs            <= runs + 1;
        cnt_reg         <= '0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end else begin
      // a request withdrawn mid-run must not shorten the next one
      cnt_reg <= '0;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tig_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  localparam int D = 10;
  logic             clk;
  logic             reset;
  logic             ce;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic [31:0]      rdata;
  logic [3:0]       passed_in_bit;
  logic [3:0]       routine_in_bit;
  logic [3:0]       routine_out_bit;
  logic             routine_done;
  logic [3:0]       returned_out_bit;
  logic             routine_req;
  logic [31:0]      elapsed_time_out;
  logic             irq;
  logic [3:0]       lat;
  logic [31:0]      v;
  logic [7:0]       addrs [6];
  logic [3:0]       ret_q [$];
  int               seed;
  int               err_total;
  int               total_checks;
  int               runs;
  int               n;
  int               steps;
  int               base;

  tig_timer #(.TICK_DIV(D), .RESP_MAX(RESP_CYCLES), .QUEUE_W(4)) dut (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .passed_in_bit(passed_in_bit), .routine_in_bit(routine_in_bit),
    .routine_out_bit(routine_out_bit), .routine_done(routine_done),
    .returned_out_bit(returned_out_bit), .routine_req(routine_req),
    .elapsed_time_out(elapsed_time_out), .irq(irq)
  );
  tig_routine_model model (
    .clk(clk), .reset(reset), .routine_req(routine_req), .routine_in_bit(routine_in_bit),
    .lat(lat), .routine_done(routine_done), .routine_out_bit(routine_out_bit), .runs(runs)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bounded wait; a stuck timer shows up as a count out of window
  task automatic wait_req(output int k);
    k = 0;
    while (routine_req !== 1'b1 && k < 5000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    seed = 32'ha7a8;
    err_total = 0;
    total_checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    passed_in_bit = 4'h0;
    lat = 4'h0;
    addrs = '{ADDR_CTRL, ADDR_SETPOINT, ADDR_ELAPSED, ADDR_STATUS, ADDR_MASK, 8'h20};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    wr_reg(8'h20, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      rd_reg(addrs[i], v);
      chk_val(v, 32'h0);
    end
    chk_val(32'({irq, routine_req}), 32'h0);
    // on-delayed: one shot, bits through the routine
    steps = 2 + $unsigned($random(seed)) % 3;
    @(posedge clk);
    passed_in_bit <= 4'($random(seed));
    lat <= 4'($unsigned($random(seed)) % 3);
    wr_reg(ADDR_SETPOINT, 32'(steps * 10));
    wr_reg(ADDR_MASK, 32'h1);
    wr_reg(ADDR_CTRL, 32'h1);
    wait_req(n);
    chk_time(n, steps * D - 2, steps * D + 3);
    chk_val(32'(irq), 32'h1);
    chk_val(32'(routine_in_bit), 32'(passed_in_bit));
    ret_q.push_back(~passed_in_bit);
    cycles(8);
    chk_val(32'(returned_out_bit), 32'(ret_q.pop_front()));
    rd_reg(ADDR_BITS, v);
    chk_val(v, {24'h0, ~passed_in_bit, passed_in_bit});
    wr_reg(ADDR_STATUS, 32'h1);
    cycles(2);
    chk_val(32'(irq), 32'h0);
    cycles(4 * steps * D);
    rd_reg(ADDR_STATUS, v);
    chk_val(32'(v[0]), 32'h0);
    wr_reg(ADDR_CTRL, 32'h0);
    // masked expiry, elapsed time, halt and load
    wr_reg(ADDR_MASK, 32'h0);
    wr_reg(ADDR_SETPOINT, 32'd50);
    wr_reg(ADDR_CTRL, 32'h1);
    cycles(2 * D + 3);
    rd_reg(ADDR_ELAPSED, v);
    chk_val(v, 32'd20);
    // clock enable low: nothing may move
    @(posedge clk);
    ce <= 1'b0;
    cycles(3 * D);
    chk_val(elapsed_time_out, 32'd20);
    ce <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h5);
    cycles(3 * D);
    rd_reg(ADDR_ELAPSED, v);
    chk_val(v, 32'd20);
    chk_val(elapsed_time_out, 32'd20);
    wr_reg(ADDR_CTRL, 32'h3);
    rd_reg(ADDR_ELAPSED, v);
    chk_val(v, 32'd0);
    wr_reg(ADDR_CTRL, 32'h1);
    wait_req(n);
    chk_time(n, 5 * D - 6, 5 * D + 3);
    rd_reg(ADDR_STATUS, v);
    chk_val(32'({irq, v[0]}), 32'h1);
    wr_reg(ADDR_MASK, 32'h1);
    cycles(2);
    chk_val(32'(irq), 32'h1);
    wr_reg(ADDR_CTRL, 32'h0);
    wr_reg(ADDR_STATUS, 32'h1);
    // interval: pulse and pause each end in a routine run
    steps = 2 + $unsigned($random(seed)) % 2;
    lat <= 4'($unsigned($random(seed)) % 3);
    wr_reg(ADDR_SETPOINT, 32'(steps * 10));
    base = runs;
    wr_reg(ADDR_CTRL, 32'h9);
    cycles(3 * steps * D + 8);
    chk_val(32'(runs - base), 32'd3);
    rd_reg(ADDR_STATUS, v);
    chk_val(32'(v[3:2]), 32'h3);
    // deactivation stops everything
    wr_reg(ADDR_CTRL, 32'h0);
    base = runs;
    cycles(4 * steps * D);
    chk_val(32'(runs - base), 32'd0);
    chk_val(32'(routine_req), 32'h0);
    tally_and_finish;
  end

  // watchdog well past the longest scenario sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
endmodule
